// [design/sshp_pkg.sv]
package sshp_pkg;
	localparam int STRAP_MS = 125; // strap hold interval in ms
	localparam int CLK_MHZ = 50; // ref_clk rate
	localparam int LINK_DIV = 16; // link clock period in ref_clk cycles (must be even)
	// strap hold in ref_clk cycles: ms times 1000 times MHz, no rounding or floor
	localparam int STRAP_CYC = STRAP_MS * 1000 * CLK_MHZ;
	localparam int NUM_GPIO = 7;
	localparam int POS_RATE0 = 0;
	localparam int POS_RATE1 = 1;
	localparam int POS_MODE = 3;
	localparam int POS_RSVD = 4;
	localparam int POS_CFG0 = 5;
	localparam int POS_CFG1 = 6;
	localparam int POS_IRQ = 2; // pin used as interrupt output in normal duty
	localparam logic [6:0] GPIO_DIR_RST = 7'h00;
	localparam logic [6:0] GPIO_OUT_RST = 7'h00;
	// apb register byte offsets
	localparam logic [7:0] REG_STRAP = 8'h00; // rw while held: strap values, ready
	localparam logic [7:0] REG_DIR = 8'h04; // rw: pin output enables
	localparam logic [7:0] REG_OUT = 8'h08; // rw: pin output levels
	localparam logic [7:0] REG_IN = 8'h0C; // ro: synchronised pin levels
	localparam logic [7:0] REG_STAT = 8'h10; // not decoded: any access answers with pslverr
	localparam int READY_BIT = 7;
endpackage : sshp_pkg

// [design/sshp_if.sv]
`timescale 1ns/100ps
`default_nettype none
// strap / general pins plus shared host pins between board side and device
interface sshp_if;
	logic [6:0] gpioDevOut; // device drive level
	logic [6:0] gpioDevOe; // device drive enable
	logic [6:0] gpioHostOut; // board/strap drive level
	logic [6:0] gpioHostOe; // board/strap drive enable
	logic linkClk; // host-made serial clock, also the device link clock
	logic sdaHostOut; // host data drive level
	logic sdaHostOe; // host data drive enable
	logic sdaDevOut; // device data drive level (I2C)
	logic sdaDevOe; // device data drive enable
	logic serOut; // device serial output pin level
	logic serOutOe; // device serial output enable
	logic selectN; // host select / address bit 0
	logic pwrN; // power-on reset, active low
	// resolve wires: device wins over pulls, pulls down for 0..5, up for 6
	function automatic logic [6:0] gpioWire();
		logic [6:0] w;
		w = 7'h40;
		for (int i = 0; i < 7; i++) begin
			if (gpioHostOe[i]) w[i] = gpioHostOut[i];
			if (gpioDevOe[i]) w[i] = gpioDevOut[i];
		end
		return w;
	endfunction : gpioWire
	// sda is pulled up; any driver low wins
	function automatic logic sdaWire();
		return !((sdaHostOe && !sdaHostOut) || (sdaDevOe && !sdaDevOut));
	endfunction : sdaWire
	modport device (
		input gpioHostOut, gpioHostOe, linkClk, sdaHostOut, sdaHostOe, selectN, pwrN,
		output gpioDevOut, gpioDevOe, sdaDevOut, sdaDevOe, serOut, serOutOe,
		import gpioWire, sdaWire
	);
	modport host (
		input gpioDevOut, gpioDevOe, sdaDevOut, sdaDevOe, serOut, serOutOe,
		output gpioHostOut, gpioHostOe, linkClk, sdaHostOut, sdaHostOe, selectN, pwrN,
		import gpioWire, sdaWire
	);
endinterface : sshp_if
`default_nettype wire

// [design/sshp_device.sv]
`timescale 1ns/100ps
`default_nettype none
// device end: strap capture, pin function select, shared host pins.
// runs on the link clock; the strap timer is counted in link clock cycles.
module sshp_device #(
	parameter int STRAP_CYC = sshp_pkg::STRAP_CYC / sshp_pkg::LINK_DIV
) (
	sshp_if.device pins, // link pins
	input wire logic [6:0] gpioDir, // normal-duty output enables
	input wire logic [6:0] gpioOut, // normal-duty output levels for pins 3..6; pins 0..2 carry lock, fail and interrupt
	input wire logic lockInd, // loop lock indication
	input wire logic refFail, // reference failure indication
	input wire logic statChange, // status change event for interrupt pin
	input wire logic irqClear, // host acknowledged interrupt
	input wire logic spiRdBit, // read data bit to shift out in SPI mode
	output logic hostModeI2c, // latched mode: 1 = I2C
	output logic [1:0] clkRate, // latched master clock rate select
	output logic [1:0] otpSel, // latched OTP config select
	output logic ready, // strap interval over
	output logic [1:0] i2cAddrLo, // address bits from shared pins
	output logic [6:0] gpioIn // synchronised pin levels
);
	parameter bit CUSTOM = 1'b0; // custom part: honour config straps
	typedef struct packed {
		logic [31:0] cnt;
		logic done;
		logic i2c;
		logic [1:0] rate;
		logic [1:0] otp;
		logic [6:0] s1, s2, s3;
		logic [6:0] in;
		logic irq;
		logic [1:0] addr;
	} sshpd_state_t;
	sshpd_state_t st_ff, nxt_st;
	logic rstL;
	assign rstL = !pins.pwrN;
	// strap counter, latch, pin sync and interrupt flag
	always_comb begin
		nxt_st = st_ff;
		nxt_st.s1 = pins.gpioWire();
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < 7; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) nxt_st.in[i] = st_ff.s2[i];
		end
		if (!st_ff.done) begin
			nxt_st.cnt = st_ff.cnt + 32'h1;
			if (st_ff.cnt >= 32'(STRAP_CYC - 1)) begin
				nxt_st.done = 1'b1;
				nxt_st.i2c = st_ff.in[sshp_pkg::POS_MODE];
				nxt_st.rate = {st_ff.in[sshp_pkg::POS_RATE1], st_ff.in[sshp_pkg::POS_RATE0]};
				nxt_st.otp = CUSTOM ? {st_ff.in[sshp_pkg::POS_CFG1],
					st_ff.in[sshp_pkg::POS_CFG0]} : 2'h0;
				nxt_st.addr = {pins.serOut, pins.selectN};
			end
		end
		// set wins over clear
		if (irqClear) nxt_st.irq = 1'b0;
		if (statChange && st_ff.done) nxt_st.irq = 1'b1;
	end
	always_ff @(posedge pins.linkClk or posedge rstL) begin
		if (rstL) st_ff <= '0;
		else st_ff <= nxt_st;
	end
	// pins released during strap window, general duty afterwards
	always_comb begin
		pins.gpioDevOe = st_ff.done ? gpioDir : 7'h00;
		pins.gpioDevOut = gpioOut;
		pins.gpioDevOut[0] = lockInd;
		pins.gpioDevOut[1] = refFail;
		pins.gpioDevOut[sshp_pkg::POS_IRQ] = st_ff.irq;
		// serial out only in SPI mode while selected; in I2C it is an address input
		pins.serOut = spiRdBit;
		pins.serOutOe = st_ff.done && !st_ff.i2c && !pins.selectN;
		pins.sdaDevOut = 1'b0;
		pins.sdaDevOe = 1'b0; // data engine lives outside this block
	end
	assign hostModeI2c = st_ff.i2c;
	assign clkRate = st_ff.rate;
	assign otpSel = st_ff.otp;
	assign ready = st_ff.done;
	assign i2cAddrLo = st_ff.addr;
	assign gpioIn = st_ff.in;
endmodule : sshp_device
`default_nettype wire

// [design/sshp_host.sv]
`timescale 1ns/100ps
`default_nettype none
// host end: drives straps for the interval, makes the link clock, apb registers
module sshp_host #(
	parameter int STRAP_CYC = sshp_pkg::STRAP_CYC
) (
	input wire logic ref_clk, // system clock
	input wire logic rst, // async reset, active high
	sshp_if.host pins, // link pins
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr // apb error
);
	localparam logic [6:0] STRAP_DEF = 7'h08; // I2C, rate 0, otp 0
	typedef struct packed {
		logic [31:0] cnt;
		logic hold;
		logic [6:0] strap;
		logic [6:0] dir, out;
		logic [6:0] s1, s2, s3, in;
		logic [3:0] div;
		logic lclk;
		logic [31:0] rdata;
		logic rdy, err;
		logic pwr;
	} sshph_state_t;
	sshph_state_t st_ff, nxt_st;
	logic acc;
	assign acc = psel && !penable;
	always_comb begin
		nxt_st = st_ff;
		nxt_st.rdy = acc;
		nxt_st.err = 1'b0;
		// device power reset lifts one cycle after rst; the link clock is still low then
		nxt_st.pwr = 1'b1;
		// free-running link clock divider
		nxt_st.div = st_ff.div + 4'h1;
		if (st_ff.div == 4'(sshp_pkg::LINK_DIV / 2 - 1)) begin
			nxt_st.div = 4'h0;
			nxt_st.lclk = !st_ff.lclk;
		end
		// keep straps driven 125 ms, then release
		if (st_ff.hold) begin
			nxt_st.cnt = st_ff.cnt + 32'h1;
			if (st_ff.cnt >= 32'(STRAP_CYC)) nxt_st.hold = 1'b0;
		end
		nxt_st.s1 = pins.gpioWire();
		nxt_st.s2 = st_ff.s1;
		nxt_st.s3 = st_ff.s2;
		for (int i = 0; i < 7; i++) begin
			if (st_ff.s2[i] == st_ff.s3[i]) nxt_st.in[i] = st_ff.s2[i];
		end
		// apb: one-cycle setup, answer in access phase
		if (acc) begin
			nxt_st.rdata = 32'h0;
			case (paddr)
				sshp_pkg::REG_STRAP: nxt_st.rdata = {24'h0, !st_ff.hold, st_ff.strap};
				sshp_pkg::REG_DIR: nxt_st.rdata = {25'h0, st_ff.dir};
				sshp_pkg::REG_OUT: nxt_st.rdata = {25'h0, st_ff.out};
				sshp_pkg::REG_IN: nxt_st.rdata = {25'h0, st_ff.in};
				default: nxt_st.err = 1'b1;
			endcase
		end
		// writes land only at the edge that sees pready, so an aborted setup changes nothing
		if (psel && penable && st_ff.rdy && pwrite) begin
			case (paddr)
				sshp_pkg::REG_STRAP: if (st_ff.hold) nxt_st.strap = pwdata[6:0];
				sshp_pkg::REG_DIR: nxt_st.dir = pwdata[6:0];
				sshp_pkg::REG_OUT: nxt_st.out = pwdata[6:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_ff <= '0;
			st_ff.hold <= 1'b1;
			st_ff.strap <= STRAP_DEF;
		end else begin
			st_ff <= nxt_st;
		end
	end
	// reserved strap forced low while held
	always_comb begin
		pins.gpioHostOe = st_ff.hold ? 7'h7F : st_ff.dir;
		pins.gpioHostOut = st_ff.hold ? (st_ff.strap & 7'h6F) : st_ff.out;
		pins.linkClk = st_ff.lclk;
		pins.sdaHostOut = 1'b1; // serial engine outside this block
		pins.sdaHostOe = 1'b0;
		pins.selectN = 1'b1;
		pins.pwrN = st_ff.pwr;
	end
	assign prdata = st_ff.rdata;
	assign pready = st_ff.rdy;
	assign pslverr = st_ff.err;
endmodule : sshp_host
`default_nettype wire

// [verif/sshp_props.sv]
`timescale 1ns/100ps
`default_nettype none
// ----
// pin checks
// ----
module sshp_props #(parameter int STRAP_CYC = 10) (
	input wire logic linkClk, // link clock
	input wire logic pwrN, // power reset
	input wire logic [6:0] gpioDevOe, // dev enables
	input wire logic [6:0] gpioHostOe, // board enables
	input wire logic [6:0] gpioHostOut, // board levels
	input wire logic sdaDevOe, // dev data enable
	input wire logic serOutOe, // serial out enable
	input wire logic selectN // select
);
	int cnt; // link cycles since release
	logic i2c; // mode seen on the strap
	// one cycle of margin each side of the latch moment
	wire early = cnt < STRAP_CYC - 1;
	wire done = cnt >= STRAP_CYC + 1;
	// counter saturates so it never wraps in long runs
	always_ff @(posedge linkClk or negedge pwrN) begin
		if (!pwrN) begin
			cnt <= 0;
			i2c <= 1'h0;
		end else begin
			if (cnt < STRAP_CYC + 1) cnt <= cnt + 1;
			if (cnt == STRAP_CYC - 2) i2c <= gpioHostOut[3];
		end
	end
	default clocking @(posedge linkClk); endclocking
	default disable iff (!pwrN);
	property p_quiet; early |-> gpioDevOe == 7'h00; endproperty
	a_quiet: assert property (p_quiet) else $error("device drove a strap");
	property p_hold; early |-> gpioHostOe[3] && (&gpioHostOe[1:0]); endproperty
	a_hold: assert property (p_hold) else $error("strap released early");
	property p_rsvd; early && gpioHostOe[4] |-> !gpioHostOut[4]; endproperty
	a_rsvd: assert property (p_rsvd) else $error("reserved strap high");
	property p_cfg; early |-> &gpioHostOe[6:5]; endproperty
	a_cfg: assert property (p_cfg) else $error("config strap released");
	property p_nosda; early |-> !sdaDevOe; endproperty
	a_nosda: assert property (p_nosda) else $error("data driven early");
	property p_spisda; done && !i2c |-> !sdaDevOe; endproperty
	a_spisda: assert property (p_spisda) else $error("data driven in spi");
	property p_i2cso; done && i2c |-> !serOutOe; endproperty
	a_i2cso: assert property (p_i2cso) else $error("serial out in i2c");
	property p_csel; serOutOe |-> !selectN; endproperty
	a_csel: assert property (p_csel) else $error("serial out unselected");
	c_i2c: cover property (done && i2c);
	c_spi: cover property (done && !i2c);
	c_sel: cover property (!selectN);
endmodule : sshp_props
`default_nettype wire

// [verif/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
// ----
// bench top
// ----
module testbench;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr, err;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [6:0] gpioDir = 7'h00, gpioOut = 7'h00, gpioIn;
	logic lockInd = 1'h0, refFail = 1'h0, statChange = 1'h0, irqClear = 1'h0;
	logic spiRdBit = 1'h0, hostModeI2c, ready;
	logic [1:0] clkRate, otpSel, i2cAddrLo;
	int errors = 0, comparisons = 0;
	always #10 ref_clk = ~ref_clk;
	sshp_if bus();
	sshp_host #(.STRAP_CYC(200)) i_sshp_host (.ref_clk(ref_clk), .rst(rst), .pins(bus),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	sshp_device #(.STRAP_CYC(10)) i_sshp_device (.pins(bus), .gpioDir(gpioDir),
		.gpioOut(gpioOut), .lockInd(lockInd), .refFail(refFail), .statChange(statChange),
		.irqClear(irqClear), .spiRdBit(spiRdBit), .hostModeI2c(hostModeI2c),
		.clkRate(clkRate), .otpSel(otpSel), .ready(ready), .i2cAddrLo(i2cAddrLo),
		.gpioIn(gpioIn));
	sshp_props #(.STRAP_CYC(10)) i_sshp_props (.linkClk(bus.linkClk), .pwrN(bus.pwrN),
		.gpioDevOe(bus.gpioDevOe), .gpioHostOe(bus.gpioHostOe),
		.gpioHostOut(bus.gpioHostOut), .sdaDevOe(bus.sdaDevOe),
		.serOutOe(bus.serOutOe), .selectN(bus.selectN));
	// one apb transfer; waits an edge first so back-to-back calls never collide
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'h1;
		// no cycle count assumed: only the watchdog ends a hung wait
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'h1);
		q = prdata;
		err = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : apb
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			errors++;
			$display("mismatch at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	task automatic results();
		$display("counts: %0d mismatches, %0d comparisons", errors, comparisons);
		if (errors == 0 && comparisons > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : results
	// straps set during the hold: i2c, rate 2, config pins high on a generic part
	task automatic t_straps();
		int n;
		n = 0;
		apb(1'h1, sshp_pkg::REG_STRAP, 32'h6A);
		apb(1'h0, sshp_pkg::REG_STRAP, 32'h0);
		chk(q, 32'h6A);
		while (q[sshp_pkg::READY_BIT] !== 1'h1 && n < 100) begin
			apb(1'h0, sshp_pkg::REG_STRAP, 32'h0);
			n++;
		end
		chk(q, 32'hEA);
		chk(32'(hostModeI2c), 32'h1);
		chk(32'(clkRate), 32'h2);
		chk(32'(otpSel), 32'h0);
		chk(32'(ready), 32'h1);
		$display("test straps done");
	endtask : t_straps
	// pins back to general use; late strap writes must not move the latch
	task automatic t_normal();
		int n;
		n = 0;
		{lockInd, refFail, statChange} <= 3'h7;
		apb(1'h1, sshp_pkg::REG_STRAP, 32'h0);
		apb(1'h1, sshp_pkg::REG_DIR, 32'h7F);
		apb(1'h1, sshp_pkg::REG_OUT, 32'h25);
		{lockInd, refFail, statChange, irqClear} <= 4'h1;
		do begin
			apb(1'h0, sshp_pkg::REG_IN, 32'h0);
			n++;
		end while (q !== 32'h25 && n < 20);
		chk(q, 32'h25);
		apb(1'h0, sshp_pkg::REG_STRAP, 32'h0);
		chk(q, 32'hEA);
		chk(32'({hostModeI2c, clkRate}), 32'h6);
		chk(32'(i2cAddrLo), 32'h1);
		// device side syncs on the slow link clock, so give it time to follow
		repeat (100) @(posedge ref_clk);
		chk(32'(gpioIn), 32'h25);
		$display("test normal done");
	endtask : t_normal
	// unmapped place answers with an error, mapped one does not
	task automatic t_unmapped();
		apb(1'h0, 8'h20, 32'h0);
		chk(32'(err), 32'h1);
		apb(1'h0, sshp_pkg::REG_DIR, 32'h0);
		chk(q, 32'h7F);
		chk(32'(err), 32'h0);
		$display("test unmapped done");
	endtask : t_unmapped
	// device drives lock, fail and interrupt on released pins; set the flag, then clear it
	task automatic t_irq();
		int n;
		n = 0;
		apb(1'h1, sshp_pkg::REG_DIR, 32'h0);
		{lockInd, refFail, statChange, irqClear} <= 4'hA;
		gpioDir <= 7'h07;
		do begin
			apb(1'h0, sshp_pkg::REG_IN, 32'h0);
			n++;
		end while (q !== 32'h45 && n < 40);
		chk(q, 32'h45);
		{statChange, irqClear} <= 2'h1;
		n = 0;
		do begin
			apb(1'h0, sshp_pkg::REG_IN, 32'h0);
			n++;
		end while (q !== 32'h41 && n < 40);
		chk(q, 32'h41);
		$display("test irq done");
	endtask : t_irq
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'h0;
		t_straps();
		t_normal();
		t_unmapped();
		t_irq();
		results();
	end
	// watchdog: the tests take well under 2000 cycles
	initial begin
		repeat (20000) @(posedge ref_clk);
		errors++;
		results();
	end
endmodule : testbench
`default_nettype wire
